//--- logic/mpd_core_dir.v
// One core's private direction register with masked update and start clear
module mpd_core_dir #(
    parameter WIDTH = 32
) (
    // Clock, reset, enable
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    // Update controls
    input  wire             start,
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_mask,
    input  wire [WIDTH-1:0] wr_data,
    // Stored value
    output reg  [WIDTH-1:0] dir
);

    wire [WIDTH-1:0] next_dir;

    assign next_dir = (dir & ~wr_mask) | (wr_data & wr_mask);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (start) begin
                dir <= {WIDTH{1'b0}};
            end else if (wr_en) begin
                dir <= next_dir;
            end
        end
    end

endmodule // mpd_core_dir

//--- logic/mpd_pin_dir.v
// Multi-core pin direction merge with APB register access
//
// Function
// - Each core owns a 32-bit direction register; bit n drives pin n.
// - Direction bit 0 requests input, 1 requests output.
// - Starting a core clears its whole direction register to zero.
// - Pin output enable is the OR of all cores' matching direction bits.
// - A disabled core contributes zeros regardless of its register contents.
// - All cores reach all pins at once; no arbitration between cores.
// - The high port direction register is reserved; no pins exist for it.
// - A single indexed bit can be written, other bits unchanged.
// - Range write: value MSB to first index, LSB to last index, either order.
// - Range read returns bits right-justified, higher result bits zero.
// - Whole register can be written, cleared, set to ones, and read.
//
// Chosen here: the APB interface to the registers and the address map.

// The address width is needed by the port list, so it comes in ahead of the header
`include "mpd_regs.vh"

module mpd_pin_dir #(
    parameter NUM_CORES = 8,
    parameter SEL_W     = 3,
    parameter PIN_W     = 32
) (
    // Clock, reset, enable
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    pce,
    // APB slave
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`MPD_ADDR_W-1:0]  paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output reg                     pready,
    output reg                     pslverr,
    // Pin output enables
    output reg  [PIN_W-1:0]        pin_oe
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire                    acc;
    wire                    wr;
    wire                    rd_setup;
    reg                     hit;
    reg                     dir_op;

    assign acc      = psel & penable;
    assign wr       = acc & pwrite & pready;
    assign rd_setup = acc & ~pready;

    always @* begin
        case (paddr)
            `MPD_OFF_CORE_SEL, `MPD_OFF_DIR, `MPD_OFF_DIR_CLR, `MPD_OFF_DIR_SET,
            `MPD_OFF_DIR_BIT, `MPD_OFF_RANGE_CTRL, `MPD_OFF_RANGE_DATA,
            `MPD_OFF_DIR_HIGH, `MPD_OFF_CORE_EN, `MPD_OFF_MERGED: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    reg  [SEL_W-1:0]        core_sel;
    reg  [NUM_CORES-1:0]    core_en;
    reg  [12:0]             range_ctrl;
    wire [NUM_CORES-1:0]    core_start;

    assign core_start = (wr && paddr == `MPD_OFF_CORE_EN) ?
                        (pwdata[NUM_CORES-1:0] & ~core_en) : {NUM_CORES{1'b0}};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_sel   <= {SEL_W{1'b0}};
            core_en    <= {NUM_CORES{1'b0}};
            range_ctrl <= `MPD_RNG_RESET;
        end else if (pce && wr) begin
            case (paddr)
                `MPD_OFF_CORE_SEL:   core_sel   <= pwdata[SEL_W-1:0];
                `MPD_OFF_CORE_EN:    core_en    <= pwdata[NUM_CORES-1:0];
                `MPD_OFF_RANGE_CTRL: range_ctrl <= pwdata[12:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Range mapping

    wire [4:0]              rng_first;
    wire [4:0]              rng_last;
    wire [4:0]              rng_lo;
    wire [4:0]              rng_hi;
    wire                    rng_down;
    wire [31:0]             sel_dir;
    reg  [PIN_W-1:0]        rng_mask;
    reg  [PIN_W-1:0]        rng_wdata;
    reg  [31:0]             rng_rdata;
    integer                 n;
    integer                 k;

    assign rng_first = range_ctrl[`MPD_RNG_FIRST];
    assign rng_last  = range_ctrl[`MPD_RNG_LAST];
    assign rng_down  = (rng_first >= rng_last);
    assign rng_lo    = rng_down ? rng_last : rng_first;
    assign rng_hi    = rng_down ? rng_first : rng_last;

    // Pin n takes value bit k, counted from the last-named index
    always @* begin
        rng_mask  = {PIN_W{1'b0}};
        rng_wdata = {PIN_W{1'b0}};
        rng_rdata = `MPD_RD_ZERO;
        k = 0;
        for (n = 0; n < PIN_W; n = n + 1) begin
            k = rng_down ? (n - rng_last) : (rng_last - n);
            if (n >= rng_lo && n <= rng_hi) begin
                rng_mask[n]  = 1'b1;
                rng_wdata[n] = pwdata[k];
                rng_rdata[k] = sel_dir[n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write mask and data for the selected core

    reg  [PIN_W-1:0]        op_mask;
    reg  [PIN_W-1:0]        op_data;

    always @* begin
        dir_op  = 1'b1;
        op_mask = `MPD_DIR_ONES;
        op_data = `MPD_DIR_RESET;
        case (paddr)
            `MPD_OFF_DIR:     op_data = pwdata;
            `MPD_OFF_DIR_CLR: op_data = `MPD_DIR_RESET;
            `MPD_OFF_DIR_SET: op_data = `MPD_DIR_ONES;
            `MPD_OFF_DIR_BIT: begin
                op_mask = `MPD_ONE_BIT << pwdata[`MPD_BIT_IDX];
                op_data = {PIN_W{pwdata[`MPD_BIT_VAL]}} & op_mask;
            end
            `MPD_OFF_RANGE_DATA: begin
                op_mask = rng_mask;
                op_data = rng_wdata;
            end
            default: dir_op = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-core direction registers

    wire [NUM_CORES*PIN_W-1:0] dir_all;

    genvar g;
    generate
        for (g = 0; g < NUM_CORES; g = g + 1) begin : g_core
            mpd_core_dir #(
                .WIDTH   (PIN_W)
            ) u_dir (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (pce),
                .start   (core_start[g]),
                .wr_en   (wr & dir_op & (core_sel == g)),
                .wr_mask (op_mask),
                .wr_data (op_data),
                .dir     (dir_all[g*PIN_W +: PIN_W])
            );
        end
    endgenerate

    assign sel_dir = dir_all[core_sel*PIN_W +: PIN_W];

    ////////////////////////////////////////////////////////////////////////////////
    // Merge of all active cores

    reg  [PIN_W-1:0]        merged;
    integer                 c;

    // A set bit means output; every core sees every pin with no arbitration
    always @* begin
        merged = {PIN_W{1'b0}};
        for (c = 0; c < NUM_CORES; c = c + 1) begin
            merged = merged | (dir_all[c*PIN_W +: PIN_W] & {PIN_W{core_en[c]}});
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= `MPD_DIR_RESET;
        end else if (pce) begin
            pin_oe <= merged;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and APB answer

    reg  [31:0]             rd_mux;

    always @* begin
        case (paddr)
            `MPD_OFF_CORE_SEL:   rd_mux = {{(32-SEL_W){1'b0}}, core_sel};
            `MPD_OFF_DIR:        rd_mux = sel_dir;
            `MPD_OFF_RANGE_CTRL: rd_mux = {19'h00000, range_ctrl};
            `MPD_OFF_RANGE_DATA: rd_mux = rng_rdata;
            `MPD_OFF_DIR_HIGH:   rd_mux = `MPD_RD_ZERO;
            `MPD_OFF_CORE_EN:    rd_mux = {{(32-NUM_CORES){1'b0}}, core_en};
            `MPD_OFF_MERGED:     rd_mux = pin_oe;
            default:             rd_mux = `MPD_RD_ZERO;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= `MPD_RD_ZERO;
            pslverr <= 1'b0;
        end else if (pce) begin
            pready  <= rd_setup;
            prdata  <= (rd_setup && !pwrite) ? rd_mux : `MPD_RD_ZERO;
            pslverr <= rd_setup & ~hit;
        end
    end

endmodule // mpd_pin_dir

//--- logic/mpd_regs.vh
// Register offsets, field positions and reset values of the pin direction merge block
`ifndef MPD_REGS_VH
`define MPD_REGS_VH

// Address width and byte offsets within the APB window
`define MPD_ADDR_W          12
`define MPD_OFF_CORE_SEL    12'h000
`define MPD_OFF_DIR         12'h004
`define MPD_OFF_DIR_CLR     12'h008
`define MPD_OFF_DIR_SET     12'h00c
`define MPD_OFF_DIR_BIT     12'h010
`define MPD_OFF_RANGE_CTRL  12'h014
`define MPD_OFF_RANGE_DATA  12'h018
`define MPD_OFF_DIR_HIGH    12'h01c
`define MPD_OFF_CORE_EN     12'h020
`define MPD_OFF_MERGED      12'h024

// Field positions
`define MPD_BIT_IDX         4:0
`define MPD_BIT_VAL         8
`define MPD_RNG_FIRST       4:0
`define MPD_RNG_LAST        12:8

// Reset and fill values
`define MPD_DIR_RESET       32'h0000_0000
`define MPD_DIR_ONES        32'hffff_ffff
`define MPD_ONE_BIT         32'h0000_0001
`define MPD_RNG_RESET       13'h0
`define MPD_RD_ZERO         32'h0000_0000

`endif

//--- tb/mpd_pin_dir_chk.sv
// Port assertions for the pin direction merge block
module mpd_pin_dir_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pce,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic [31:0] pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_end = psel && penable && pready && !pwrite;
    wire wr_end = psel && penable && pready && pwrite;
    wait_one_a: assert property (psel && penable && !pready && pce && !$past(penable) |=> pready)
        else $error("pready late");
    one_cycle_a: assert property (pready && pce |=> !pready) else $error("pready held");
    err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
    high_port_a: assert property (rd_end && paddr == 12'h01c |-> prdata == 32'h0 && !pslverr)
        else $error("high port read");
    merged_rd_a: assert property (rd_end && paddr == 12'h024 |-> prdata == pin_oe)
        else $error("merged read");
    oe_cause_a: assert property ($changed(pin_oe) |-> $past(wr_end, 2) || $past(wr_end, 3))
        else $error("pin_oe moved alone");
    freeze_all_a: assert property (!pce |=> $stable(pin_oe) && $stable(pready))
        else $error("moved while frozen");
    start_zero_a: assert property (!$past(presetn) |-> pin_oe == 32'h0 && !pready)
        else $error("not clear at start");
endmodule // mpd_pin_dir_chk

bind mpd_pin_dir mpd_pin_dir_chk u_chk (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_oe(pin_oe));

//--- tb/mpd_pin_ext.sv
// External circuitry model on the port pins
module mpd_pin_ext (
    // Clock
    input  wire logic        pclk,
    // Directions from the block
    input  wire logic [31:0] pin_oe,
    // Pad levels
    output logic      [31:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] drv = 32'h5555_5555;
    // Input pins never hold a level the simulator could settle for us
    always @(posedge pclk) drv <= ~drv;
    assign pad = ~pin_oe & drv;
endmodule // mpd_pin_ext

//--- tb/tb.sv
// Self-checking bench for the pin direction merge block
`include "mpd_regs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        pce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rdata;
    logic        rerr;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [31:0] pin_oe;
    wire  [31:0] pad;
    int          err_total = 0;
    int          total_checks = 0;

    initial forever #12.5 pclk = ~pclk;

    mpd_pin_dir u_mpd_pin_dir (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_oe(pin_oe));
    mpd_pin_ext u_mpd_pin_ext (.pclk(pclk), .pin_oe(pin_oe), .pad(pad));

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Sample the answer at the rising edge, then release right after it
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    task automatic pins(input logic [31:0] e);
        @(posedge pclk);
        @(negedge pclk);
        chk(pin_oe, e);
        chk(pad & e, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_rst;
        rd(12'h020, 32'h0);
        rd(12'h004, `MPD_DIR_RESET);
        wr(12'h01c, `MPD_DIR_ONES);
        rd(12'h01c, 32'h0);
        chk(pin_oe, 32'h0);
        $display("t_rst done");
    endtask

    task automatic t_all;
        wr(12'h020, 32'h1);
        wr(12'h004, 32'h0000_b0f3);
        pins(32'h0000_b0f3);
        rd(12'h004, 32'h0000_b0f3);
        wr(12'h008, 32'h0);
        rd(12'h004, 32'h0);
        wr(12'h00c, 32'h0);
        rd(12'h024, `MPD_DIR_ONES);
        $display("t_all done");
    endtask

    task automatic t_bit;
        wr(12'h008, 32'h0);
        wr(12'h010, 32'h105);
        wr(12'h010, 32'h11f);
        rd(12'h004, 32'h8000_0020);
        wr(12'h010, 32'h005);
        rd(12'h004, 32'h8000_0000);
        $display("t_bit done");
    endtask

    task automatic t_rng;
        wr(12'h008, 32'h0);
        wr(12'h014, 32'h0305);
        wr(12'h018, 32'h6);
        rd(12'h004, 32'h30);
        wr(12'h008, 32'h0);
        wr(12'h014, 32'h0503);
        wr(12'h018, 32'h6);
        rd(12'h004, 32'h18);
        wr(12'h004, 32'ha0);
        wr(12'h014, 32'h0407);
        rd(12'h018, 32'ha);
        $display("t_rng done");
    endtask

    task automatic t_mrg;
        wr(12'h004, 32'h3);
        wr(12'h020, 32'h3);
        wr(12'h000, 32'h1);
        rd(12'h004, 32'h0);
        wr(12'h004, 32'h0f00);
        pins(32'h0f03);
        wr(12'h020, 32'h1);
        rd(12'h004, 32'h0f00);
        chk(pin_oe, 32'h3);
        wr(12'h020, 32'h3);
        rd(12'h004, 32'h0);
        $display("t_mrg done");
    endtask

    task automatic t_err;
        fork
            apb(1'b0, 12'h100, 32'h0);
            begin
                @(posedge pclk);
                pce <= 1'b0;
                repeat (3) @(posedge pclk);
                pce <= 1'b1;
            end
        join
        chk({31'h0, rerr}, 32'h1);
        chk(rdata, 32'h0);
        wr(12'h024, 32'h0);
        rd(12'h024, 32'h3);
        $display("t_err done");
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_rst();
        t_all();
        t_bit();
        t_rng();
        t_mrg();
        t_err();
        print_verdict();
    end
endmodule // tb
